// ### common/sef_pkg.sv
// Notes on behaviour
// - sample data in on rising serial clock, change data out from falling edge.
// - power-on reset: ignore commands, deselected, standby, latch and busy cleared.
// - no selection until chip select has fallen after power-up.
// - select low means active; deselected enters standby only without a write cycle.
// - pause only while selected; paused output floats, data and clock ignored.
// - pause starts when pause_n falls with serial clock low; here it takes effect at any serial clock level.
// - pause freezes bit and byte sequencing; transfer resumes where it stopped.
// - deselect during pause resets command logic, keeps latch and busy flag.
// - a complete write command still launches when deselected during pause; here status writes and latch commands do not.
// - writes and status writes execute only with a multiple of eight clocks.
// - data-modifying commands need the write latch set beforehand.
// - protect field 00 none, 01 upper quarter, 10 upper half, 11 all.
// - write protect input guards the protect field against status writes.
// - execute only if select rises between final bit edge and next edge.
// - final bit is an opcode or data byte end; reads are exempt.
// - commands arrive as whole bytes, msb first, opcode then address and data.
// - undefined opcode waits, ignoring input, until deselected.
// - opcodes: set latch 06, clear latch 04, read status 05, write status 01.
// - opcodes: read 03, write 02, read id page 83, write id page 82.
// - lock read and lock commands share id opcodes, address with only b10 set.
// - three address bytes; array uses A17..A0, id page A7..A0, upper zero.
// - lock bit set with write protect low makes status write refused.
// - write latch clears on power-up, clear command, end of any write cycle.
// - deselected output stays high impedance.
package sef_pkg;
	// opcodes
	localparam logic [7:0] OPC_SET_WEL = 8'h06;
	localparam logic [7:0] OPC_CLR_WEL = 8'h04;
	localparam logic [7:0] OPC_RD_STAT = 8'h05;
	localparam logic [7:0] OPC_WR_STAT = 8'h01;
	localparam logic [7:0] OPC_RD_ARR = 8'h03;
	localparam logic [7:0] OPC_WR_ARR = 8'h02;
	localparam logic [7:0] OPC_RD_ID = 8'h83;
	localparam logic [7:0] OPC_WR_ID = 8'h82;
	// address forms and protect field codes
	localparam logic [23:0] ADDR_LOCK = 24'h00_0400;
	localparam logic [15:0] ID_UPPER_ZERO = 16'h0000;
	localparam logic [17:0] PROT_QUARTER_BASE = 18'h3_0000;
	localparam logic [17:0] PROT_HALF_BASE = 18'h2_0000;
	localparam logic [1:0] BP_NONE = 2'h0;
	localparam logic [1:0] BP_QUARTER = 2'h1;
	localparam logic [1:0] BP_HALF = 2'h2;
	// byte counts of a frame
	localparam logic [8:0] NB_OPC_ONLY = 9'h001;
	localparam logic [8:0] NB_STATUS_WR = 9'h002;
	localparam logic [8:0] NB_HEADER = 9'h004;
	localparam logic [8:0] NB_MAX = 9'h1FF;
	// status byte positions
	localparam int ST_BUSY = 0;
	localparam int ST_WEL = 1;
	localparam int ST_BP0 = 2;
	localparam int ST_BP1 = 3;
	localparam int ST_LOCK = 7;
	// write cycle time
	localparam int T_WRITE_MS = 10;
	localparam int CLK_KHZ = 200000;
	localparam int WRITE_CYCLES = T_WRITE_MS * CLK_KHZ;
	localparam int TIMER_W = 24;
	// reset values
	localparam logic [7:0] STATUS_RST = 8'h00;
	// executed write kinds
	localparam logic [1:0] EX_ARRAY = 2'h0;
	localparam logic [1:0] EX_ID = 2'h1;
	localparam logic [1:0] EX_LOCK = 2'h2;
	localparam logic [1:0] EX_STATUS = 2'h3;

	typedef enum logic [4:0] {
		L_OPC = 5'b00001,
		L_ADDR = 5'b00010,
		L_DATA = 5'b00100,
		L_SEND = 5'b01000,
		L_WAIT = 5'b10000
	} sef_lstate_t;

	// non-volatile status and id lock bits
	typedef struct packed {
		logic status_lock_bit;
		logic id_lock;
		logic [1:0] bp;
	} sef_nv_t;

	// what the frame left behind at deselect
	typedef struct packed {
		logic frame_ok;
		logic undef;
		logic got_dat;
		logic [7:0] opc;
		logic [23:0] addr;
		logic [7:0] dat;
		logic [8:0] nbytes;
		logic [2:0] bits;
	} sef_info_t;

	// launched write cycle
	typedef struct packed {
		logic valid;
		logic [1:0] kind;
		logic [23:0] addr;
		logic [7:0] dat;
		logic [8:0] nbytes;
	} sef_exec_t;

	// read address toward the array
	typedef struct packed {
		logic id_page;
		logic [17:0] addr;
	} sef_rd_t;
endpackage : sef_pkg

// ### logic/sef_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module sef_front_end
	import sef_pkg::*;
#(
	parameter int unsigned WRITE_CYC = WRITE_CYCLES
) (
	// system clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// serial link pins
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_sdi,
	input wire logic i_pause_n,
	input wire logic i_wp_n,
	output logic o_sdo,
	output logic o_sdo_oe,
	// array read side, on the serial clock
	output sef_rd_t o_rd,
	input wire logic [7:0] i_rd_data,
	// non-volatile storage
	input wire sef_nv_t i_nv_init,
	output sef_nv_t o_nv,
	// write launch and status
	output sef_exec_t o_exec,
	output logic [7:0] o_status,
	output logic o_active,
	output logic o_standby
);
	// link side state
	typedef struct packed {
		sef_lstate_t state;
		logic rd_arr;
		logic id_page;
		logic [7:0] sh;
		sef_info_t info;
	} sef_link_t;

	// system side state
	typedef struct packed {
		logic load;
		logic cs_prev;
		logic busy;
		logic write_enable_latch;
		sef_nv_t nv;
		sef_nv_t pend;
		logic [1:0] pend_kind;
		logic [TIMER_W-1:0] timer;
		sef_exec_t exec;
		logic [7:0] status;
		logic active;
		logic standby;
	} sef_sys_t;

	sef_link_t l_q, l_d, base;
	sef_sys_t s_q, s_d;
	logic armed_q;
	logic fresh_q;
	logic fresh_set;
	logic tx_clr;
	logic sdo_q, oe_q;
	logic [2:0] pins_s;
	logic cs_s, pause_s, wp_s;
	logic [7:0] status_l;
	logic [7:0] out_byte;
	logic [7:0] shifted;
	logic byte_done;
	logic [8:0] nb_inc;
	logic aligned, paused, hw_prot, addr_prot, id_upper_ok, is_lock, wr_hdr_ok;
	logic [TIMER_W-1:0] write_len;

	assign write_len = TIMER_W'(WRITE_CYC);

	// pins into the system clock domain
	sef_sync #(
		.W(3),
		.RST_VAL(3'h7)
	) u_pin_sync (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_d({i_cs_n, i_pause_n, i_wp_n}),
		.o_q(pins_s)
	);
	assign cs_s = pins_s[2];
	assign pause_s = pins_s[1];
	assign wp_s = pins_s[0];

	// status byte into the link domain
	sef_sync #(
		.W(8),
		.RST_VAL(STATUS_RST)
	) u_stat_sync (
		.i_clk(i_sclk),
		.i_resetn(i_resetn),
		.i_d(s_q.status),
		.o_q(status_l)
	);

	// armed only by a falling select after reset
	always_ff @(negedge i_cs_n or negedge i_resetn) begin
		if (!i_resetn) begin
			armed_q <= 1'b0;
		end else begin
			armed_q <= 1'b1;
		end
	end

	// marks the first serial edge of a frame
	assign fresh_set = i_cs_n || !i_resetn;
	always_ff @(posedge i_sclk or posedge fresh_set) begin
		if (fresh_set) begin
			fresh_q <= 1'b1;
		end else begin
			fresh_q <= 1'b0;
		end
	end

	// link next state, one step per rising serial edge
	always_comb begin
		base = l_q;
		if (fresh_q) begin
			base.state = L_OPC;
			base.rd_arr = 1'b0;
			base.id_page = 1'b0;
			base.info = '0;
			base.info.frame_ok = armed_q;
		end
		shifted = {base.sh[6:0], i_sdi}; // msb first
		byte_done = (base.info.bits == 3'h7); // eighth bit of a byte
		nb_inc = (base.info.nbytes == NB_MAX) ? NB_MAX : base.info.nbytes + 9'h001;
		l_d = base;
		// edges while deselected, e.g. a mode change of the idle level, are ignored
		if (!i_pause_n || i_cs_n) begin
			l_d = l_q; // pause freezes sequencing
		end else begin
			l_d.sh = shifted; // sample on rising edge
			l_d.info.bits = base.info.bits + 3'h1;
			if (byte_done) begin
				l_d.info.nbytes = nb_inc;
			end
			unique case (base.state)
				L_OPC: begin
					if (byte_done) begin
						l_d.info.opc = shifted;
						unique case (shifted)
							OPC_RD_STAT: l_d.state = L_SEND;
							OPC_SET_WEL, OPC_CLR_WEL: l_d.state = L_WAIT;
							OPC_WR_STAT: l_d.state = L_DATA;
							OPC_RD_ARR, OPC_WR_ARR: l_d.state = L_ADDR;
							OPC_RD_ID, OPC_WR_ID: begin
								l_d.state = L_ADDR;
								l_d.id_page = 1'b1;
							end
							default: begin
								l_d.state = L_WAIT;
								l_d.info.undef = 1'b1;
							end
						endcase
					end
				end
				L_ADDR: begin
					if (byte_done) begin
						l_d.info.addr = {base.info.addr[15:0], shifted};
						if (base.info.nbytes == (NB_HEADER - 9'h001)) begin
							if (base.info.opc[0]) begin
								l_d.state = L_SEND;
								l_d.rd_arr = 1'b1;
							end else begin
								l_d.state = L_DATA;
							end
						end
					end
				end
				L_DATA: begin
					if (byte_done && !base.info.got_dat) begin
						l_d.info.dat = shifted;
						l_d.info.got_dat = 1'b1;
					end
				end
				L_SEND: begin
					// next array byte, id page wraps inside its page
					if (byte_done && base.rd_arr) begin
						if (base.id_page) begin
							l_d.info.addr[7:0] = base.info.addr[7:0] + 8'h01;
						end else begin
							l_d.info.addr[17:0] = base.info.addr[17:0] + 18'h0_0001;
						end
					end
				end
				L_WAIT: begin
					l_d.state = L_WAIT; // input ignored until deselect
				end
			endcase
		end
	end

	// link register, held over deselect for the system side
	always_ff @(posedge i_sclk or negedge i_resetn) begin
		if (!i_resetn) begin
			l_q <= '{state: L_OPC, default: '0};
		end else begin
			l_q <= l_d;
		end
	end

	// byte shifted out: array data or status
	assign out_byte = l_q.rd_arr ? i_rd_data : status_l;

	// output stage on the falling edge, floats when deselected or paused
	assign tx_clr = !i_resetn || i_cs_n || !i_pause_n;
	always_ff @(negedge i_sclk or posedge tx_clr) begin
		if (tx_clr) begin
			sdo_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			sdo_q <= out_byte[~l_q.info.bits];
			// a mode-3 frame falls before its first rising edge: l_q is still stale then
			oe_q <= !fresh_q && (l_q.state == L_SEND) && l_q.info.frame_ok;
		end
	end
	assign o_sdo = sdo_q;
	assign o_sdo_oe = oe_q;
	assign o_rd = '{id_page: l_q.id_page, addr: l_q.info.addr[17:0]};

	// checks on the frame left at deselect
	always_comb begin
		aligned = (l_q.info.bits == 3'h0);
		paused = !pause_s;
		hw_prot = s_q.nv.status_lock_bit && !wp_s;
		unique case (s_q.nv.bp)
			BP_NONE: addr_prot = 1'b0;
			BP_QUARTER: addr_prot = (l_q.info.addr[17:0] >= PROT_QUARTER_BASE);
			BP_HALF: addr_prot = (l_q.info.addr[17:0] >= PROT_HALF_BASE);
			default: addr_prot = 1'b1;
		endcase
		id_upper_ok = (l_q.info.addr[23:8] == ID_UPPER_ZERO);
		is_lock = (l_q.info.addr == ADDR_LOCK);
		wr_hdr_ok = aligned && (l_q.info.nbytes > NB_HEADER);
	end

	// system next state
	always_comb begin
		s_d = s_q;
		s_d.exec.valid = 1'b0;
		s_d.cs_prev = cs_s;
		if (s_q.load) begin
			s_d.load = 1'b0;
			s_d.nv = i_nv_init; // non-volatile bits kept over reset
		end
		// write cycle timing and completion
		if (s_q.busy) begin
			if (s_q.timer == '0) begin
				s_d.busy = 1'b0;
				s_d.write_enable_latch = 1'b0;
				if (s_q.pend_kind == EX_STATUS) begin
					s_d.nv.status_lock_bit = s_q.pend.status_lock_bit;
					s_d.nv.bp = s_q.pend.bp;
				end
				if (s_q.pend_kind == EX_LOCK) begin
					s_d.nv.id_lock = 1'b1;
				end
			end else begin
				s_d.timer = s_q.timer - TIMER_W'(1);
			end
		end
		// decision at deselect; reads need nothing
		if (cs_s && !s_q.cs_prev && l_q.info.frame_ok && !l_q.info.undef
				&& !s_q.busy && !s_q.load) begin
			s_d.exec.addr = l_q.info.addr;
			s_d.exec.dat = l_q.info.dat;
			s_d.exec.nbytes = l_q.info.nbytes;
			unique case (l_q.info.opc)
				OPC_SET_WEL: begin
					if (!paused && aligned && l_q.info.nbytes == NB_OPC_ONLY) begin
						s_d.write_enable_latch = 1'b1;
					end
				end
				OPC_CLR_WEL: begin
					if (!paused && aligned && l_q.info.nbytes == NB_OPC_ONLY) begin
						s_d.write_enable_latch = 1'b0;
					end
				end
				OPC_WR_STAT: begin
					if (!paused && aligned && l_q.info.nbytes == NB_STATUS_WR
							&& s_q.write_enable_latch && !hw_prot) begin
						s_d.busy = 1'b1;
						s_d.timer = write_len;
						s_d.pend_kind = EX_STATUS;
						s_d.pend.status_lock_bit = l_q.info.dat[ST_LOCK];
						s_d.pend.bp = {l_q.info.dat[ST_BP1], l_q.info.dat[ST_BP0]};
						s_d.exec.valid = 1'b1;
						s_d.exec.kind = EX_STATUS;
					end
				end
				OPC_WR_ARR: begin
					if (wr_hdr_ok && s_q.write_enable_latch && !addr_prot) begin
						s_d.busy = 1'b1; // launches even when paused
						s_d.timer = write_len;
						s_d.pend_kind = EX_ARRAY;
						s_d.exec.valid = 1'b1;
						s_d.exec.kind = EX_ARRAY;
					end
				end
				OPC_WR_ID: begin
					if (wr_hdr_ok && s_q.write_enable_latch && !s_q.nv.id_lock
							&& (id_upper_ok || is_lock)) begin
						s_d.busy = 1'b1;
						s_d.timer = write_len;
						s_d.pend_kind = is_lock ? EX_LOCK : EX_ID;
						s_d.exec.valid = 1'b1;
						s_d.exec.kind = is_lock ? EX_LOCK : EX_ID;
					end
				end
				default: begin
					s_d.busy = s_q.busy;
				end
			endcase
		end
		// registered status outputs
		s_d.status = STATUS_RST;
		s_d.status[ST_BUSY] = s_d.busy;
		s_d.status[ST_WEL] = s_d.write_enable_latch;
		s_d.status[ST_BP0] = s_d.nv.bp[0];
		s_d.status[ST_BP1] = s_d.nv.bp[1];
		s_d.status[ST_LOCK] = s_d.nv.status_lock_bit;
		s_d.active = !cs_s;
		s_d.standby = cs_s && !s_d.busy;
	end

	// system register; latch and busy clear on reset
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_q <= '{load: 1'b1, cs_prev: 1'b1, standby: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign o_nv = s_q.nv;
	assign o_exec = s_q.exec;
	assign o_status = s_q.status;
	assign o_active = s_q.active;
	assign o_standby = s_q.standby;
endmodule : sef_front_end
`default_nettype wire

// ### logic/sef_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sef_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// data
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_q;

	// two-stage synchroniser, first stage read only by the second
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta_q <= RST_VAL;
			o_q <= RST_VAL;
		end else begin
			meta_q <= i_d;
			o_q <= meta_q;
		end
	end
endmodule : sef_sync
`default_nettype wire

// ### verification/sef_front_end_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sef_fe_asserts
	import sef_pkg::*;
#(
	parameter int unsigned WRITE_CYC = 50
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// pins and status
	input wire logic i_cs_n,
	input wire logic i_pause_n,
	input wire logic i_wp_n,
	input wire logic o_sdo_oe,
	input wire sef_nv_t o_nv,
	input wire sef_exec_t o_exec,
	input wire logic [7:0] o_status,
	input wire logic o_standby,
	input wire logic o_active
);
	localparam int BUSY_MAX = WRITE_CYC + 8;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);
	// output floats when not selected or paused
	a_sdo_desel: assert property (i_cs_n |-> !o_sdo_oe)
		else $error("data out driven while deselected");
	a_sdo_pause: assert property (!i_pause_n |-> !o_sdo_oe)
		else $error("data out driven while paused");
	// clean state on release
	a_rst_idle: assert property ($rose(i_resetn) |-> o_status[1:0] == 2'h0 && o_standby)
		else $error("not idle after reset");
	// launch needs latch and deselect
	a_exec_wel: assert property (o_exec.valid |-> o_status[ST_WEL] && i_cs_n)
		else $error("write launched without latch or while selected");
	// busy held, then busy and latch cleared in time
	a_busy_hold: assert property (o_exec.valid |-> ##2 o_status[ST_BUSY] [*8])
		else $error("busy flag not held");
	a_cycle_end: assert property (o_exec.valid |-> ##[2:BUSY_MAX] o_status[1:0] == 2'h0)
		else $error("latch or busy not cleared after write");
	a_stby_idle: assert property ((i_cs_n && !o_status[ST_BUSY]) [*5] |-> o_standby)
		else $error("no standby while idle");
	a_active_sel: assert property ((!i_cs_n) [*4] |-> o_active)
		else $error("not active while selected");
	// protection of array and status
	a_prot_area: assert property (o_exec.valid && o_exec.kind == EX_ARRAY |->
		o_nv.bp == BP_NONE || (o_nv.bp == BP_HALF && !o_exec.addr[17]) ||
		(o_nv.bp == BP_QUARTER && o_exec.addr[17:16] != 2'h3))
		else $error("write launched into protected area");
	a_hw_lock: assert property (o_exec.valid && o_exec.kind == EX_STATUS |->
		!(o_nv.status_lock_bit && !i_wp_n))
		else $error("status write launched while locked");
	// main scenarios
	c_arr: cover property (o_exec.valid && o_exec.kind == EX_ARRAY);
	c_stat: cover property (o_exec.valid && o_exec.kind == EX_STATUS);
	c_read: cover property (o_sdo_oe);
endmodule : sef_fe_asserts
`default_nettype wire

// ### verification/sef_spi_mst.sv
`timescale 1ns/1ps
`default_nettype none
module sef_spi_mst (
	// link pins
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_sdi,
	output logic o_pause_n,
	input wire logic i_sdo,
	input wire logic i_sdo_oe
);
	logic cpol = 1'b0;
	logic [15:0] rx_q = 16'h0000;
	// select low from power-up, no edge yet
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b0;
		o_sdi = 1'b0;
		o_pause_n = 1'b1;
	end
	// one frame, msb first; optional pause before bit pb, abort while paused
	task automatic frame(input logic [39:0] tx, input int nb, rb, pb, input bit ab);
		#1.3; // off the system clock edges
		o_sclk = cpol;
		#80 o_cs_n = 1'b0;
		#80;
		for (int i = 0; i < nb + rb; i++) begin
			o_sclk = 1'b0;
			if (i == pb) begin
				#20 o_pause_n = 1'b0;
				repeat (4) #40 {o_sclk, o_sdi} = ~{o_sclk, o_sdi};
				#20;
				if (ab) begin
					o_cs_n = 1'b1;
					#40 o_pause_n = 1'b1;
					return;
				end
				o_pause_n = 1'b1;
			end
			o_sdi = (i < nb) ? tx[39 - i] : ~o_sdi;
			#80 o_sclk = 1'b1;
			rx_q = {rx_q[14:0], i_sdo_oe ? i_sdo : ~rx_q[0]};
			#80;
		end
		o_sclk = cpol;
		#40 o_cs_n = 1'b1;
		o_sdi = ~o_sdi;
		#400;
	endtask : frame
endmodule : sef_spi_mst
`default_nettype wire

// ### verification/tb_sef_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sef_front_end;
	import sef_pkg::*;
	localparam int unsigned WC = 50;
	typedef struct packed {
		logic [39:0] tx;
		logic [7:0] nb;
		logic [3:0] st;
		logic [3:0] ne;
	} sef_row_t;
	logic i_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_wp_n = 1'b1;
	sef_nv_t nv_init = 4'h0;
	logic sclk, cs_n, sdi, pause_n, sdo, sdo_oe, stby, act;
	sef_rd_t rd;
	sef_nv_t nv;
	sef_exec_t ex, last;
	logic [7:0] st;
	int num_errors = 0;
	int num_checks = 0;
	int n_ex = 0;
	sef_row_t rows [16] = '{
		'{40'h06_0000_0000, 8'h08, 4'h0, 4'h0}, '{40'h06_0000_0000, 8'h08, 4'h2, 4'h0},
		'{40'h04_0000_0000, 8'h08, 4'h0, 4'h0}, '{40'hAB_0600_0000, 8'h10, 4'h0, 4'h0},
		'{40'h02_0000_1055, 8'h28, 4'h0, 4'h0}, '{40'h06_0000_0000, 8'h08, 4'h2, 4'h0},
		'{40'h02_0000_1055, 8'h27, 4'h2, 4'h0}, '{40'h02_0000_1055, 8'h28, 4'h0, 4'h1},
		'{40'h06_0000_0000, 8'h08, 4'h2, 4'h1}, '{40'h01_0C00_0000, 8'h10, 4'hC, 4'h2},
		'{40'h06_0000_0000, 8'h08, 4'hE, 4'h2}, '{40'h02_0000_1055, 8'h28, 4'hE, 4'h2},
		'{40'h01_0400_0000, 8'h10, 4'h4, 4'h3}, '{40'h06_0000_0000, 8'h08, 4'h6, 4'h3},
		'{40'h02_0300_0011, 8'h28, 4'h6, 4'h3}, '{40'h02_02FF_FF11, 8'h28, 4'h4, 4'h4}};
	// clock
	initial forever #2.5 i_clk = ~i_clk;
	// design and far-side master
	sef_front_end #(.WRITE_CYC(WC)) uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_sclk(sclk),
		.i_cs_n(cs_n), .i_sdi(sdi), .i_pause_n(pause_n), .i_wp_n(i_wp_n), .o_sdo(sdo),
		.o_sdo_oe(sdo_oe), .o_rd(rd), .i_rd_data(rd.addr[7:0] ^ 8'hA5), .i_nv_init(nv_init),
		.o_nv(nv), .o_exec(ex), .o_status(st), .o_active(act), .o_standby(stby));
	sef_spi_mst m (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .o_pause_n(pause_n),
		.i_sdo(sdo), .i_sdo_oe(sdo_oe));
	// launched writes
	always @(posedge i_clk) if (ex.valid === 1'b1) begin
		last <= ex;
		n_ex <= n_ex + 1;
	end
	task automatic chk(input string nm, input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic idle();
		repeat (200) if (st[0] !== 1'b0) @(posedge i_clk);
		repeat (10) @(posedge i_clk);
	endtask : idle
	// latch then command
	task automatic wr(input logic [39:0] tx, input int nb, rb, pb, input bit ab);
		m.frame(40'h06_0000_0000, 8, 0, -1, 0);
		m.frame(tx, nb, rb, pb, ab);
		idle();
	endtask : wr
	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test
	// watchdog
	initial begin
		#400000;
		num_errors++;
		stop_test();
	end
	// main sequence
	initial begin
		repeat (20) @(posedge i_clk);
		i_resetn <= 1'b1;
		repeat (10) @(posedge i_clk);
		foreach (rows[k]) begin
			m.frame(rows[k].tx, int'(rows[k].nb), 0, -1, 0);
			idle();
			chk("status", st[3:0], rows[k].st);
			chk("writes", n_ex, rows[k].ne);
		end
		m.frame(40'h06_0000_0000, 8, 0, -1, 0);
		m.frame(40'h05_0000_0000, 8, 8, -1, 0);
		chk("rd_status", m.rx_q[7:0], 8'h06);
		m.cpol = 1'b1;
		m.frame(40'h03_FC12_3400, 32, 16, -1, 0);
		chk("rd_array", m.rx_q, {8'h34 ^ 8'hA5, 8'h35 ^ 8'hA5});
		wr(40'h02_0000_203C, 40, 0, 20, 0);
		chk("paused_wr", {last.addr, last.dat}, 32'h0000_203C);
		chk("wr_len", last.nbytes, 9'h005);
		wr(40'h02_0000_2177, 40, 1, 40, 1);
		chk("held_wr", {last.addr, last.dat}, 32'h0000_2177);
		wr(40'h02_0000_2200, 40, 0, 20, 1);
		chk("abort_wr", n_ex, 6);
		chk("abort_wel", st[1], 1'b1);
		wr(40'h82_0000_1055, 40, 0, -1, 0);
		chk("id_wr", last.kind, EX_ID);
		wr(40'h82_0004_0000, 40, 0, -1, 0);
		chk("lock", last.kind, EX_LOCK);
		wr(40'h01_8000_0000, 16, 0, -1, 0);
		@(posedge i_clk) i_wp_n <= 1'b0;
		wr(40'h01_0C00_0000, 16, 0, -1, 0);
		chk("hw_lock", nv, 4'hC);
		chk("hw_wr", n_ex, 9);
		@(posedge i_clk) nv_init <= 4'h8;
		i_resetn <= 1'b0;
		repeat (3) @(posedge i_clk);
		i_resetn <= 1'b1;
		repeat (4) @(posedge i_clk);
		chk("reset", {nv, st[1:0], stby, act}, {4'h8, 2'h0, 1'b1, 1'b0});
		stop_test();
	end
endmodule : tb_sef_front_end
bind sef_front_end sef_fe_asserts #(.WRITE_CYC(WRITE_CYC)) chk_i (.i_clk(i_clk),
	.i_resetn(i_resetn), .i_cs_n(i_cs_n), .i_pause_n(i_pause_n), .i_wp_n(i_wp_n),
	.o_sdo_oe(o_sdo_oe), .o_nv(o_nv), .o_exec(o_exec), .o_status(o_status),
	.o_standby(o_standby), .o_active(o_active));
`default_nettype wire
